// ==== rtl/vtr_regs.sv ====
`timescale 1ns/10ps
`include "vtr_defs.svh"

module vtr_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("vtr_fifo depth must be a power of two");
   end

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_valid_o = (count_q != '0);
   assign out_data_o = mem_q[rd_q];

   always_ff @(posedge clock_i) begin
      if (push)
         mem_q[wr_q] <= in_data_i;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
         in_ready_o <= 1'b1;
      end else begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
            in_ready_o <= (count_q != (AW+1)'(DEPTH - 1));
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
            in_ready_o <= 1'b1;
         end
      end
   end
endmodule : vtr_fifo

// Function
// RL1 - Pointer write picks a register; data access reaches it; pointer read gives status.
// RL2 - Done set when transfer or fill ends, cleared by character port access.
// RL3 - Chip reset write only sets done, nothing else.
// RL4 - Processor issues chip reset before any normal operation.
// RL5 - Top of screen low seven bits give address bits 10..4, low four zero.
// RL6 - Top of screen bit 7 picks retrace set A or B.
// RL7 - Cursor low holds address bits 7..0; transfers start at cursor.
// RL8 - Cursor high holds address bits 10..8 and scroll offset in 6..3.
// RL9 - Cursor high bit 7 enables status row, only for 25 rows.
// RL10 - Attribute bits 3..0 act on tagged characters, live on screen.
// RL11 - Attribute bit 7 selects graphics display without attributes.
// RL12 - Attribute bit 6 forces background level during cursor time.
// RL13 - Attribute bit 5 picks underline cursor, dashed over underlined character.
// RL14 - Attribute bit 4 sets whole screen polarity.
// RL15 - Attribute bit 3 suppresses video of tagged characters.
// RL16 - Attribute bit 2 drives intensity high for tagged characters.
// RL17 - Attribute bit 1 underlines, bit 0 reverses tagged characters.
// RL18 - Byte write to character port stores it at the character address.
// RL19 - Character port read returns byte and starts the next fetch.
// RL20 - Armed fill: character port write starts a fill with that byte.
// RL21 - Display memory transfers only during retrace blanking.
// RL22 - Graphics mode: tag one alphanumeric, tag zero graphics, bit 6 wide.
// RL23 - Graphics bits 3..0 light segments 4..1; 5..4 segments 6..5 wide only.
// RL24 - Mode bit 7 increments character address after each transfer.
module vtr_regs #(
   parameter bit ROWS_25 = 1'b1,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic cpu_sel_pointer_i,
   input wire logic cpu_wr_i,
   input wire logic cpu_rd_i,
   input wire logic [7:0] cpu_data_i,
   output logic [7:0] cpu_data_o,
   output logic cpu_full_o,
   input wire logic blank_i,
   output logic [10:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   output logic mem_we_o,
   output logic mem_re_o,
   input wire logic [7:0] mem_rdata_i,
   output logic [10:0] top_of_screen_o,
   output logic retrace_set_select_o,
   output logic [3:0] smooth_scroll_offset_o,
   output logic status_row_enable_o,
   input wire vtr_pkg::vtr_pixel_t pixel_i,
   output logic video_o,
   output logic intensity_output_o
);
   localparam int REQ_W = $bits(vtr_pkg::vtr_req_t);

   logic [`VTR_SEL_W-1:0] pointer_q;
   logic done_q;
   logic [7:0] cursor_low_q;
   logic [7:0] cursor_high_q;
   logic [6:0] fill_end_q;
   logic fill_armed_q;
   logic [7:0] attribute_q;
   logic auto_inc_q;
   logic [7:0] char_q;
   logic [10:0] char_addr_q;
   logic [10:0] fill_addr_q;
   vtr_pkg::vtr_state_t state_q;
   vtr_pkg::vtr_req_t req_in;
   vtr_pkg::vtr_req_t req_out;
   logic req_valid;
   logic req_ready;
   logic fifo_full;
   logic fifo_full_n;
   logic fifo_ready;
   logic data_wr;
   logic data_rd;
   logic char_wr;
   logic char_rd;
   logic take;
   logic finish;

   initial begin
      if (FIFO_DEPTH < 2)
         $error("vtr_regs fifo depth too small");
   end

   function automatic logic [10:0] cursor_addr(input logic [7:0] hi,
                                              input logic [7:0] lo);
      cursor_addr = {hi[2:0], lo};
   endfunction : cursor_addr

   assign data_wr = cpu_wr_i && !cpu_sel_pointer_i;
   assign data_rd = cpu_rd_i && !cpu_sel_pointer_i;
   assign char_wr = data_wr && pointer_q == `VTR_SEL_CHARACTER;
   assign char_rd = data_rd && pointer_q == `VTR_SEL_CHARACTER;

   // Requests queue while the engine waits for blanking
   always_comb begin
      req_in.data = cpu_data_i;
      if (char_rd)
         req_in.op = vtr_pkg::VTR_OP_READ; // see RL19
      else if (fill_armed_q)
         req_in.op = vtr_pkg::VTR_OP_FILL; // see RL20
      else
         req_in.op = vtr_pkg::VTR_OP_WRITE; // see RL18
   end

   assign fifo_ready = !fifo_full;

   vtr_fifo #(
      .WIDTH(REQ_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .in_valid_i(char_wr || char_rd),
      .in_ready_o(fifo_full_n),
      .in_data_i(req_in),
      .out_valid_o(req_valid),
      .out_ready_i(req_ready),
      .out_data_o(req_out)
   );
   assign fifo_full = !fifo_full_n;

   // Transfers are taken only inside blanking
   assign take = state_q == vtr_pkg::VTR_ST_IDLE && req_valid && blank_i; // see RL21
   assign req_ready = take;

   always_ff @(posedge clock_i) begin
      if (reset_i)
         cpu_full_o <= 1'b0;
      else
         cpu_full_o <= fifo_full;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i)
         pointer_q <= '0;
      else if (cpu_wr_i && cpu_sel_pointer_i)
         pointer_q <= cpu_data_i[`VTR_SEL_W-1:0]; // see RL1
   end

   // Chip reset deliberately leaves every register except done alone
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         cursor_low_q <= `VTR_RESET_BYTE;
         cursor_high_q <= `VTR_RESET_BYTE;
         fill_end_q <= '0;
         attribute_q <= `VTR_RESET_BYTE;
         auto_inc_q <= 1'b0;
         top_of_screen_o <= `VTR_RESET_ADDR;
         retrace_set_select_o <= 1'b0;
      end else if (data_wr) begin
         case (pointer_q)
            `VTR_SEL_TOP_OF_SCREEN: begin
               top_of_screen_o <= {cpu_data_i[6:0], 4'h0}; // see RL5
               retrace_set_select_o <= cpu_data_i[`VTR_TOS_RETRACE_BIT]; // see RL6
            end
            `VTR_SEL_CURSOR_LOW: cursor_low_q <= cpu_data_i; // see RL7
            `VTR_SEL_CURSOR_HIGH: cursor_high_q <= cpu_data_i; // see RL8
            `VTR_SEL_FILL_END: fill_end_q <= cpu_data_i[6:0];
            `VTR_SEL_ATTRIBUTE: attribute_q <= cpu_data_i; // see RL10
            `VTR_SEL_MODE: auto_inc_q <= cpu_data_i[`VTR_MODE_AUTO_INC_BIT];
            default: ;
         endcase
      end
   end

   always_comb begin
      smooth_scroll_offset_o =
         cursor_high_q[`VTR_CURSOR_ADDRESS_HIGH_SCROLL_SS_MSB:`VTR_CURSOR_ADDRESS_HIGH_SCROLL_SS_LSB]; // see RL8
      status_row_enable_o =
         ROWS_25 && cursor_high_q[`VTR_CURSOR_ADDRESS_HIGH_SCROLL_SLE_BIT]; // see RL9
   end

   // Fill arms on a fill end write and disarms once queued
   always_ff @(posedge clock_i) begin
      if (reset_i)
         fill_armed_q <= 1'b0;
      else if (data_wr && pointer_q == `VTR_SEL_FILL_END)
         fill_armed_q <= 1'b1;
      else if (char_wr && fifo_ready)
         fill_armed_q <= 1'b0;
   end

   // Transfer engine
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_q <= vtr_pkg::VTR_ST_IDLE;
         mem_we_o <= 1'b0;
         mem_re_o <= 1'b0;
         mem_addr_o <= `VTR_RESET_ADDR;
         mem_wdata_o <= `VTR_RESET_BYTE;
         fill_addr_q <= `VTR_RESET_ADDR;
      end else begin
         mem_we_o <= 1'b0;
         mem_re_o <= 1'b0;
         case (state_q)
            vtr_pkg::VTR_ST_IDLE: begin
               if (take) begin
                  mem_addr_o <= char_addr_q; // see RL7
                  mem_wdata_o <= req_out.data;
                  fill_addr_q <= char_addr_q;
                  case (req_out.op)
                     vtr_pkg::VTR_OP_READ: begin
                        mem_re_o <= 1'b1; // see RL19
                        state_q <= vtr_pkg::VTR_ST_READ_WAIT;
                     end
                     vtr_pkg::VTR_OP_FILL:
                        state_q <= vtr_pkg::VTR_ST_FILL; // see RL20
                     default: begin
                        mem_we_o <= 1'b1; // see RL18
                        state_q <= vtr_pkg::VTR_ST_WRITE;
                     end
                  endcase
               end
            end
            vtr_pkg::VTR_ST_WRITE, vtr_pkg::VTR_ST_READ:
               state_q <= vtr_pkg::VTR_ST_IDLE;
            vtr_pkg::VTR_ST_READ_WAIT:
               state_q <= vtr_pkg::VTR_ST_READ;
            vtr_pkg::VTR_ST_FILL: begin
               // Fill pauses outside blanking and resumes later
               if (fill_addr_q[10:4] == fill_end_q && fill_addr_q[3:0] == 4'h0)
                  state_q <= vtr_pkg::VTR_ST_IDLE;
               else if (blank_i) begin // see RL21
                  mem_we_o <= 1'b1;
                  mem_addr_o <= fill_addr_q;
                  fill_addr_q <= fill_addr_q + 11'h001;
               end
            end
            default: state_q <= vtr_pkg::VTR_ST_IDLE;
         endcase
      end
   end

   assign finish = state_q == vtr_pkg::VTR_ST_WRITE
      || state_q == vtr_pkg::VTR_ST_READ
      || (state_q == vtr_pkg::VTR_ST_FILL && fill_addr_q[10:4] == fill_end_q
          && fill_addr_q[3:0] == 4'h0);

   // Cursor load resets the character address; fill leaves it alone
   always_ff @(posedge clock_i) begin
      if (reset_i)
         char_addr_q <= `VTR_RESET_ADDR;
      else if (data_wr && pointer_q == `VTR_SEL_CURSOR_LOW)
         char_addr_q <= cursor_addr(cursor_high_q, cpu_data_i); // see RL7
      else if (data_wr && pointer_q == `VTR_SEL_CURSOR_HIGH)
         char_addr_q <= cursor_addr(cpu_data_i, cursor_low_q);
      else if (auto_inc_q && (state_q == vtr_pkg::VTR_ST_WRITE
                              || state_q == vtr_pkg::VTR_ST_READ))
         char_addr_q <= char_addr_q + 11'h001; // see RL24
   end

   always_ff @(posedge clock_i) begin
      if (reset_i)
         char_q <= `VTR_RESET_BYTE;
      else if (state_q == vtr_pkg::VTR_ST_READ)
         char_q <= mem_rdata_i; // see RL19
      else if (char_wr)
         char_q <= cpu_data_i;
   end

   // Transfer end raises done only when nothing else is queued or arriving; chip reset sets it regardless
   always_ff @(posedge clock_i) begin
      if (reset_i)
         done_q <= 1'b0;
      else if (data_wr && pointer_q == `VTR_SEL_CHIP_RESET)
         done_q <= 1'b1; // see RL3
      else if (char_wr || char_rd)
         done_q <= 1'b0; // see RL2
      else if (finish && !req_valid)
         done_q <= 1'b1; // see RL2
   end

   always_ff @(posedge clock_i) begin
      if (reset_i)
         cpu_data_o <= `VTR_RESET_BYTE;
      else if (cpu_rd_i && cpu_sel_pointer_i)
         cpu_data_o <= {done_q, 7'h00}; // see RL1
      else if (char_rd)
         cpu_data_o <= char_q; // see RL19
      else if (data_rd)
         cpu_data_o <= `VTR_RESET_BYTE;
   end

   // Pixel attribute path
   logic tag;
   logic graphics;
   logic attr_on;
   logic [5:0] seg_mask;
   logic fg;
   logic bg_level;
   logic pix;

   always_comb begin
      tag = pixel_i.chr[`VTR_CHAR_TAG_BIT];
      graphics = attribute_q[`VTR_ATT_GRAPHICS_BIT]; // see RL11
      attr_on = !graphics && tag; // see RL10
      seg_mask = pixel_i.chr[`VTR_CHAR_WIDE_BIT]
         ? pixel_i.chr[5:0] : {2'b00, pixel_i.chr[3:0]}; // see RL23
      if (graphics && !tag)
         fg = |(seg_mask & pixel_i.segment); // see RL22
      else
         fg = pixel_i.glyph_dot;
      if (attr_on && attribute_q[`VTR_ATT_CHAR_SUPPRESS_BIT])
         fg = 1'b0; // see RL15
      if (attr_on && attribute_q[`VTR_ATT_UNDERLINE_BIT])
         fg = fg || pixel_i.underline_row; // see RL17
      if (pixel_i.cursor) begin
         if (!attribute_q[`VTR_ATT_CSR_UNDERLINE_BIT])
            fg = !fg; // see RL13
         else if (pixel_i.underline_row)
            fg = (attr_on && attribute_q[`VTR_ATT_UNDERLINE_BIT])
               ? pixel_i.dash_phase : 1'b1; // see RL13
      end
      bg_level = attribute_q[`VTR_ATT_SCREEN_WHITE_BIT]; // see RL14
      if (attr_on && attribute_q[`VTR_ATT_REVERSE_BIT])
         bg_level = !bg_level; // see RL17
      pix = fg ? !bg_level : bg_level;
      if (pixel_i.cursor && attribute_q[`VTR_ATT_CSR_SUPPRESS_BIT])
         pix = attribute_q[`VTR_ATT_SCREEN_WHITE_BIT]; // see RL12
      if (ROWS_25 && pixel_i.status_row && !status_row_enable_o)
         pix = attribute_q[`VTR_ATT_SCREEN_WHITE_BIT]; // see RL9
      if (!pixel_i.active)
         pix = 1'b0;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         video_o <= 1'b0;
         intensity_output_o <= 1'b0;
      end else begin
         video_o <= pix;
         intensity_output_o <= pixel_i.active && attr_on
            && attribute_q[`VTR_ATT_INTENSITY_BIT]; // see RL16
      end
   end

   property p_pointer;
      @(posedge clock_i) disable iff (reset_i)
      cpu_wr_i && cpu_sel_pointer_i
         |=> pointer_q == $past(cpu_data_i[3:0]);
   endproperty
   a_pointer: assert property (p_pointer) // see RL1
      else $error("pointer not loaded");

   property p_done_clear;
      @(posedge clock_i) disable iff (reset_i)
      (char_wr || char_rd) |=> !done_q;
   endproperty
   a_done_clear: assert property (p_done_clear) // see RL2
      else $error("done not cleared by character access");

   property p_chip_reset;
      @(posedge clock_i) disable iff (reset_i)
      data_wr && pointer_q == `VTR_SEL_CHIP_RESET
         |=> done_q && $stable(top_of_screen_o) && $stable(attribute_q);
   endproperty
   a_chip_reset: assert property (p_chip_reset) // see RL3
      else $error("chip reset changed state");

   property p_tos_low;
      @(posedge clock_i) disable iff (reset_i)
      top_of_screen_o[3:0] == 4'h0;
   endproperty
   a_tos_low: assert property (p_tos_low) // see RL5
      else $error("top of screen low bits not zero");

   property p_blank_only;
      @(posedge clock_i) disable iff (reset_i)
      (mem_we_o || mem_re_o) |-> $past(blank_i);
   endproperty
   a_blank_only: assert property (p_blank_only) // see RL21
      else $error("memory access outside blanking");

   property p_byte_write;
      @(posedge clock_i) disable iff (reset_i)
      take && req_out.op == vtr_pkg::VTR_OP_WRITE
         |=> mem_we_o && mem_wdata_o == $past(req_out.data)
             && mem_addr_o == $past(char_addr_q);
   endproperty
   a_byte_write: assert property (p_byte_write) // see RL18
      else $error("byte write not stored at character address");

   property p_auto_inc;
      @(posedge clock_i) disable iff (reset_i)
      auto_inc_q && state_q == vtr_pkg::VTR_ST_WRITE
         && !data_wr |=> char_addr_q == $past(char_addr_q) + 11'h001;
   endproperty
   a_auto_inc: assert property (p_auto_inc) // see RL24
      else $error("character address not incremented");

   property p_read_fetch;
      @(posedge clock_i) disable iff (reset_i)
      take && req_out.op == vtr_pkg::VTR_OP_READ
         |=> mem_re_o ##2 char_q == $past(mem_rdata_i);
   endproperty
   a_read_fetch: assert property (p_read_fetch) // see RL19
      else $error("read fetch not captured");

   property p_intensity;
      @(posedge clock_i) disable iff (reset_i)
      pixel_i.active && attr_on && attribute_q[`VTR_ATT_INTENSITY_BIT]
         |=> intensity_output_o;
   endproperty
   a_intensity: assert property (p_intensity) // see RL16
      else $error("intensity not driven for tagged character");
endmodule : vtr_regs

// ==== rtl/vtr_defs.svh ====
`ifndef VTR_DEFS_SVH
`define VTR_DEFS_SVH
// Register select codes held in the pointer register
`define VTR_SEL_W 4
`define VTR_SEL_CHIP_RESET 4'h6
`define VTR_SEL_TOP_OF_SCREEN 4'h8
`define VTR_SEL_CURSOR_LOW 4'h9
`define VTR_SEL_CURSOR_HIGH 4'hA
`define VTR_SEL_FILL_END 4'hB
`define VTR_SEL_ATTRIBUTE 4'hC
`define VTR_SEL_CHARACTER 4'hD
`define VTR_SEL_MODE 4'hE
// Field positions
`define VTR_STATUS_DONE_BIT 7
`define VTR_TOS_RETRACE_BIT 7
`define VTR_CURSOR_ADDRESS_HIGH_SCROLL_SLE_BIT 7
`define VTR_CURSOR_ADDRESS_HIGH_SCROLL_SS_MSB 6
`define VTR_CURSOR_ADDRESS_HIGH_SCROLL_SS_LSB 3
`define VTR_CHAR_TAG_BIT 7
`define VTR_CHAR_WIDE_BIT 6
`define VTR_ATT_GRAPHICS_BIT 7
`define VTR_ATT_CSR_SUPPRESS_BIT 6
`define VTR_ATT_CSR_UNDERLINE_BIT 5
`define VTR_ATT_SCREEN_WHITE_BIT 4
`define VTR_ATT_CHAR_SUPPRESS_BIT 3
`define VTR_ATT_INTENSITY_BIT 2
`define VTR_ATT_UNDERLINE_BIT 1
`define VTR_ATT_REVERSE_BIT 0
`define VTR_MODE_AUTO_INC_BIT 7
// Reset values
`define VTR_RESET_BYTE 8'h00
`define VTR_RESET_ADDR 11'h000
`endif

// ==== rtl/vtr_pkg.sv ====
package vtr_pkg;
   typedef enum logic [1:0] {
      VTR_OP_WRITE,
      VTR_OP_READ,
      VTR_OP_FILL
   } vtr_op_t;
   typedef struct packed {
      vtr_op_t op;
      logic [7:0] data;
   } vtr_req_t;
   typedef enum logic [2:0] {
      VTR_ST_IDLE,
      VTR_ST_WRITE,
      VTR_ST_READ,
      VTR_ST_READ_WAIT,
      VTR_ST_FILL
   } vtr_state_t;
   typedef struct packed {
      logic [7:0] chr;
      logic glyph_dot;
      logic underline_row;
      logic [5:0] segment;
      logic dash_phase;
      logic cursor;
      logic status_row;
      logic active;
   } vtr_pixel_t;
endpackage : vtr_pkg

// ==== dv/vtr_cpu_model.sv ====
`timescale 1ns/10ps
`include "vtr_defs.svh"
module vtr_cpu_model (
   input wire logic clock_i,
   output logic cpu_sel_pointer_o,
   output logic cpu_wr_o,
   output logic cpu_rd_o,
   output logic [7:0] cpu_data_o,
   input wire logic [7:0] cpu_data_i
);
   initial begin
      cpu_sel_pointer_o = 1'b1;
      cpu_wr_o = 1'b0;
      cpu_rd_o = 1'b0;
      cpu_data_o = 8'h00;
   end
   // One-edge strobe; released bus shows the inverse, not stale data
   task automatic access(input logic sel, input logic wr, input logic [7:0] d);
      @(posedge clock_i);
      cpu_sel_pointer_o <= sel;
      cpu_wr_o <= wr;
      cpu_rd_o <= ~wr;
      cpu_data_o <= d;
      @(posedge clock_i);
      cpu_wr_o <= 1'b0;
      cpu_rd_o <= 1'b0;
      cpu_data_o <= ~d;
   endtask : access
   task automatic select(input logic [3:0] code);
      access(1'b1, 1'b1, {4'h0, code});
   endtask : select
   task automatic put(input logic [7:0] d);
      access(1'b0, 1'b1, d);
   endtask : put
   task automatic get(input logic sel, output logic [7:0] d);
      access(sel, 1'b0, 8'h00);
      @(posedge clock_i);
      #1 d = cpu_data_i;
   endtask : get
   // Polls status; ok stays low if the flag never rises
   task automatic wait_done(output logic ok);
      logic [7:0] s;
      ok = 1'b0;
      for (int i = 0; i < 400 && !ok; i++) begin
         get(1'b1, s);
         ok = (s[`VTR_STATUS_DONE_BIT] === 1'b1);
      end
   endtask : wait_done
   // Two-step reset; the testbench issues it after a first status read
   task automatic chip_reset();
      select(`VTR_SEL_CHIP_RESET);
      put(8'hA5);
   endtask : chip_reset
endmodule : vtr_cpu_model

// ==== dv/video_terminal_register_set_tb_top.sv ====
`timescale 1ns/10ps
`include "vtr_defs.svh"
module video_terminal_register_set_tb_top;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic sel, wr, rd, full, mem_we, mem_re, retrace, status_row_enable, video, inten, ok;
   logic blank_i = 1'b0;
   logic blank_q = 1'b0;
   logic blank_hold = 1'b0;
   logic [7:0] wdata, rdata, mem_wdata, mem_rdata, b, r, att, c;
   logic [7:0] wq [0:7];
   logic [10:0] mem_addr, tos, rd_addr = 11'h000;
   logic [3:0] scroll;
   logic [1:0] e;
   vtr_pkg::vtr_pixel_t pixel = '0;
   vtr_pkg::vtr_pixel_t p;
   logic [7:0] mem [0:2047];
   int rd_hold = 0;
   int k;
   int n_fail = 0;
   int checks_done = 0;
   integer seed = 25;

   always #20 clock_i = ~clock_i;

   vtr_cpu_model u_cpu (.clock_i(clock_i), .cpu_sel_pointer_o(sel),
      .cpu_wr_o(wr), .cpu_rd_o(rd), .cpu_data_o(wdata), .cpu_data_i(rdata));

   vtr_regs #(.ROWS_25(1'b1), .FIFO_DEPTH(8)) u_dut (.clock_i(clock_i),
      .reset_i(reset_i), .cpu_sel_pointer_i(sel), .cpu_wr_i(wr),
      .cpu_rd_i(rd), .cpu_data_i(wdata), .cpu_data_o(rdata),
      .cpu_full_o(full), .blank_i(blank_i), .mem_addr_o(mem_addr),
      .mem_wdata_o(mem_wdata), .mem_we_o(mem_we), .mem_re_o(mem_re),
      .mem_rdata_i(mem_rdata), .top_of_screen_o(tos),
      .retrace_set_select_o(retrace), .smooth_scroll_offset_o(scroll),
      .status_row_enable_o(status_row_enable), .pixel_i(pixel), .video_o(video),
      .intensity_output_o(inten));

   task automatic check(input logic [10:0] got, input logic [10:0] exp,
                        input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got,
                  exp);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   // Display memory; read data only valid while a fetch is pending
   always @(posedge clock_i) begin
      if (!reset_i && (mem_we || mem_re))
         check(11'(blank_q), 11'h001, "access outside blanking");
      blank_q <= blank_i;
      blank_i <= blank_hold ? 1'b0 : (($random(seed) % 4) != 0);
      if (mem_we)
         mem[mem_addr] <= mem_wdata;
      if (mem_re) begin
         rd_addr <= mem_addr;
         rd_hold <= 3;
      end else if (rd_hold > 0)
         rd_hold <= rd_hold - 1;
   end
   assign mem_rdata = mem_re ? mem[mem_addr] :
                      (rd_hold > 0) ? mem[rd_addr] : ~mem[rd_addr];

   function automatic logic [7:0] seed_byte(input logic [10:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction : seed_byte

   // Returns {video, intensity}; k is the segment of the cell under the pixel
   function automatic logic [1:0] exp_pix(input logic [7:0] a,
      input logic [7:0] ch, input vtr_pkg::vtr_pixel_t q, input int k);
      logic tag;
      logic dot;
      logic ulc;
      tag = ch[7] & ~a[7];
      ulc = tag & a[1];
      dot = (a[7] && !ch[7]) ? ch[k] & (k < 4 || ch[6]) : q.glyph_dot;
      dot = (dot & ~(tag & a[3])) | (ulc & q.underline_row);
      if (q.cursor && !a[5])
         dot = ~dot;
      else if (q.cursor && q.underline_row)
         dot = ulc ? q.dash_phase : 1'b1;
      if (q.status_row || (q.cursor && a[6]))
         return {a[4], tag & a[2]};
      return {dot ^ a[4] ^ (tag & a[0]), tag & a[2]};
   endfunction : exp_pix

   task automatic settle();
      u_cpu.wait_done(ok);
      if (!ok) begin
         check(11'h000, 11'h001, "done flag timeout");
         complete_run();
      end
   endtask : settle

   task automatic write_reg(input logic [3:0] code, input logic [7:0] d);
      u_cpu.select(code);
      u_cpu.put(d);
   endtask : write_reg

   task automatic set_cursor(input logic [10:0] a);
      write_reg(`VTR_SEL_CURSOR_LOW, a[7:0]);
      write_reg(`VTR_SEL_CURSOR_HIGH, {5'h00, a[10:8]});
   endtask : set_cursor

   initial begin
      for (int i = 0; i < 2048; i++)
         mem[i] = seed_byte(11'(i));
      repeat (4) @(posedge clock_i);
      reset_i <= 1'b0;
      u_cpu.get(1'b1, r);
      check(11'(r), 11'h000, "status after reset");
      u_cpu.chip_reset();
      u_cpu.get(1'b1, r);
      check(11'(r), 11'h080, "status after chip reset");
      // Corner values first, then random
      for (int i = 0; i < 6; i++) begin
         b = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
         r = b ^ 8'h3C;
         write_reg(`VTR_SEL_TOP_OF_SCREEN, b);
         write_reg(`VTR_SEL_CURSOR_HIGH, r);
         repeat (2) @(posedge clock_i);
         check(tos, {b[6:0], 4'h0}, "top address");
         check(11'(retrace), 11'(b[7]), "retrace set");
         check(11'(scroll), 11'(r[6:3]), "scroll offset");
         check(11'(status_row_enable), 11'(r[7]), "status row enable");
      end
      u_cpu.chip_reset();
      check(tos, {b[6:0], 4'h0}, "top kept by chip reset");
      check(11'(scroll), 11'(r[6:3]), "scroll kept by reset");
      u_cpu.select(`VTR_SEL_TOP_OF_SCREEN);
      u_cpu.get(1'b0, r);
      check(11'(r), 11'h000, "write-only readback");
      // Byte writes with auto increment; first one held out of blanking
      set_cursor(11'h2A5);
      write_reg(`VTR_SEL_MODE, 8'h80);
      blank_hold = 1'b1;
      for (int i = 0; i < 3; i++) begin
         wq[i] = 8'($random(seed));
         write_reg(`VTR_SEL_CHARACTER, wq[i]);
         if (i == 0) begin
            u_cpu.get(1'b1, r);
            check(11'(r[7]), 11'h000, "done after port write");
            blank_hold = 1'b0;
         end
         settle();
      end
      for (int i = 0; i < 3; i++)
         check(11'(mem[11'h2A5 + i]), 11'(wq[i]), "stored byte");
      // First read only primes the port
      set_cursor(11'h300);
      u_cpu.select(`VTR_SEL_CHARACTER);
      u_cpu.get(1'b0, r);
      settle();
      for (int i = 0; i < 2; i++) begin
         u_cpu.get(1'b0, r);
         check(11'(r), 11'(seed_byte(11'(32'h300 + i))), "fetched byte");
         settle();
      end
      // Fill up to the end boundary, neighbours untouched
      write_reg(`VTR_SEL_MODE, 8'h00);
      set_cursor(11'h100);
      write_reg(`VTR_SEL_FILL_END, 8'h12);
      write_reg(`VTR_SEL_CHARACTER, 8'hC3);
      settle();
      for (int a = 11'h0FF; a <= 11'h120; a++)
         check(11'(mem[a]), (a >= 11'h100 && a < 11'h120) ? 11'h0C3 :
               11'(seed_byte(11'(a))), "fill contents");
      // Queue byte writes while blanking is held off, then drains in order
      write_reg(`VTR_SEL_MODE, 8'h80);
      blank_hold = 1'b1;
      set_cursor(11'h400);
      u_cpu.select(`VTR_SEL_CHARACTER);
      for (int i = 0; i < 8; i++) begin
         wq[i] = 8'($random(seed));
         u_cpu.put(wq[i]);
      end
      repeat (2) @(posedge clock_i);
      #1 check(11'(full), 11'h001, "queue full");
      blank_hold = 1'b0;
      settle();
      for (int i = 0; i < 8; i++)
         check(11'(mem[11'h400 + i]), 11'(wq[i]), "queued byte");
      // Random attributes and cells; status row is off here
      for (int i = 0; i < 48; i++) begin
         att = 8'($random(seed));
         if (att[3])
            att[0] = 1'b0;
         c = 8'($random(seed));
         write_reg(`VTR_SEL_ATTRIBUTE, att);
         repeat (2) @(posedge clock_i);
         p = '0;
         p.chr = c;
         p.glyph_dot = 1'($random(seed));
         p.active = 1'b1;
         k = {$random(seed)} % 6;
         p.segment = 6'h01 << k;
         {p.underline_row, p.dash_phase, p.cursor, p.status_row} =
            4'($random(seed));
         pixel <= p;
         @(posedge clock_i);
         #1 e = exp_pix(att, c, p, k);
         check(11'(video), 11'(e[1]), "video level");
         check(11'(inten), 11'(e[0]), "intensity");
      end
      complete_run();
   end
endmodule : video_terminal_register_set_tb_top
